// *** epir_top.sv ***
// External pin interrupt request generator with Avalon-MM registers
// Notes on behaviour
// - Edge mode sets request bit on selected edge; held until accepted.
// - Edge mode: software 0 cancels request, software 1 raises one.
// - Level mode ignores the stored request bit.
// - Level mode requests continuously while pin is at valid level.
// - Level mode drops request unrecorded when pin goes invalid first.
// - Valid level chosen by polarity bit 4; invalid is the opposite.
// - Level-to-edge or polarity change may set request bit spuriously.
// - New priority level takes effect 2 to 7 cycles after the write.
// - Detection time bits 5:4: 00 is 7, 01 is 4, 10 is 2 cycles.
// - Sense/polarity: 00 fall, 01 rise, 10 high level, 11 low level.
// - Pins watched always; level 0 suppresses that source's request.
`timescale 1ns/1ps
`default_nettype none

module epir_top #(
    parameter int NUM_PINS = epir_pkg::NUM_PINS
) (
    input wire logic clk, // System clock, 100 MHz
    input wire logic reset_n, // Asynchronous reset
    input wire logic [epir_pkg::ADDR_W-1:0] avs_address, // Byte address
    input wire logic avs_read, // Read strobe
    input wire logic avs_write, // Write strobe
    input wire logic [epir_pkg::DATA_W-1:0] avs_writedata, // Write data
    output logic [epir_pkg::DATA_W-1:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall while high
    input wire logic [NUM_PINS-1:0] ext_irq_pin, // Interrupt input pins
    input wire logic [NUM_PINS-1:0] irq_accept, // Request accepted pulse
    output logic [NUM_PINS-1:0] irq_request, // Requests presented
    output logic [NUM_PINS*epir_pkg::LVL_W-1:0] irq_level, // Effective levels
    output logic [7:0] port_two_pin_direction, // Port two directions
    output logic [7:0] port_five_pin_direction, // Port five directions
    output logic [7:0] port_seven_pin_direction // Port seven directions
);

    function automatic logic [epir_pkg::CNT_W-1:0] det_cycles(
        input logic [epir_pkg::DET_W-1:0] sel
    );
        case (sel)
            epir_pkg::DET_SEL_4: det_cycles = epir_pkg::DET_CYC_4;
            epir_pkg::DET_SEL_2: det_cycles = epir_pkg::DET_CYC_2;
            // Forbidden code falls back to the slowest setting
            default: det_cycles = epir_pkg::DET_CYC_7;
        endcase
    endfunction

    function automatic logic addr_is(
        input logic [epir_pkg::ADDR_W-1:0] addr,
        input logic [7:0] idx
    );
        addr_is = (addr == {idx, 2'b00});
    endfunction

    // Bus slave state
    logic wait_q;
    logic next_wait;
    logic [epir_pkg::DATA_W-1:0] rdata_q;
    logic [epir_pkg::DATA_W-1:0] next_rdata;
    logic [7:0] p2_dir;
    logic [7:0] next_p2_dir;
    logic [7:0] p5_dir;
    logic [7:0] next_p5_dir;
    logic [7:0] p7_dir;
    logic [7:0] next_p7_dir;
    logic [epir_pkg::DET_W-1:0] det_sel;
    logic [epir_pkg::DET_W-1:0] next_det_sel;

    // Per-pin state
    epir_pkg::epir_ctrl_type ctrl [NUM_PINS];
    epir_pkg::epir_ctrl_type next_ctrl [NUM_PINS];
    logic [epir_pkg::LVL_W-1:0] eff_lvl [NUM_PINS];
    logic [epir_pkg::LVL_W-1:0] next_eff_lvl [NUM_PINS];
    logic [epir_pkg::CNT_W-1:0] lvl_cnt [NUM_PINS];
    logic [epir_pkg::CNT_W-1:0] next_lvl_cnt [NUM_PINS];
    logic [NUM_PINS-1:0] sync1;
    logic [NUM_PINS-1:0] sync2;
    logic [NUM_PINS-1:0] sel_prev;
    logic [NUM_PINS-1:0] next_sel_prev;
    logic [NUM_PINS-1:0] req_q;
    logic [NUM_PINS-1:0] next_req;
    logic [NUM_PINS*epir_pkg::LVL_W-1:0] lvl_out_q;
    logic [NUM_PINS*epir_pkg::LVL_W-1:0] next_lvl_out;

    logic bus_hit;
    logic wr_take;

    // Answer one cycle after the request is seen; write lands on the edge after that
    always_comb begin
        bus_hit = (avs_read || avs_write) && wait_q;
        wr_take = avs_write && !wait_q;
        next_wait = !bus_hit;
        next_rdata = rdata_q;
        next_p2_dir = p2_dir;
        next_p5_dir = p5_dir;
        next_p7_dir = p7_dir;
        next_det_sel = det_sel;
        if (bus_hit && avs_read) begin
            next_rdata = epir_pkg::READ_ZERO;
            if (addr_is(avs_address, epir_pkg::IDX_P2_DIR)) begin
                next_rdata[7:0] = p2_dir;
            end else if (addr_is(avs_address, epir_pkg::IDX_P5_DIR)) begin
                next_rdata[7:0] = p5_dir;
            end else if (addr_is(avs_address, epir_pkg::IDX_P7_DIR)) begin
                next_rdata[7:0] = p7_dir;
            end else if (addr_is(avs_address, epir_pkg::IDX_DET_TIME)) begin
                next_rdata[epir_pkg::DET_LO +: epir_pkg::DET_W] = det_sel;
            end else if (addr_is(avs_address, epir_pkg::IDX_STATUS)) begin
                next_rdata[NUM_PINS-1:0] = req_q;
                next_rdata[epir_pkg::STAT_PIN_LO +: NUM_PINS] = sync2;
            end
            for (int i = 0; i < NUM_PINS; i++) begin
                if (addr_is(avs_address, epir_pkg::IDX_CTRL_BASE + 8'(i))) begin
                    next_rdata[epir_pkg::CTRL_W-1:0] = ctrl[i];
                end
            end
        end
        if (wr_take) begin
            // direction bits, 1 drives the pin
            if (addr_is(avs_address, epir_pkg::IDX_P2_DIR)) begin
                next_p2_dir = avs_writedata[7:0];
            end
            if (addr_is(avs_address, epir_pkg::IDX_P5_DIR)) begin
                next_p5_dir = avs_writedata[7:0] & epir_pkg::P5_DIR_MASK;
            end
            if (addr_is(avs_address, epir_pkg::IDX_P7_DIR)) begin
                next_p7_dir = avs_writedata[7:0];
            end
            if (addr_is(avs_address, epir_pkg::IDX_DET_TIME)) begin
                next_det_sel = avs_writedata[epir_pkg::DET_LO +: epir_pkg::DET_W];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_q <= 1'b1;
            rdata_q <= epir_pkg::READ_ZERO;
            p2_dir <= epir_pkg::DIR_RESET;
            p5_dir <= epir_pkg::DIR_RESET;
            p7_dir <= epir_pkg::DIR_RESET;
            det_sel <= epir_pkg::DET_RESET;
        end else begin
            wait_q <= next_wait;
            rdata_q <= next_rdata;
            p2_dir <= next_p2_dir;
            p5_dir <= next_p5_dir;
            p7_dir <= next_p7_dir;
            det_sel <= next_det_sel;
        end
    end

    // Pin detection, request bits and delayed priority levels
    always_comb begin
        logic sel_now;
        logic hit_edge;
        logic valid_lvl;
        logic wr_ctrl;
        sel_now = 1'b0;
        hit_edge = 1'b0;
        valid_lvl = 1'b0;
        wr_ctrl = 1'b0;
        next_req = '0;
        next_lvl_out = '0;
        for (int i = 0; i < NUM_PINS; i++) begin
            // polarity 0 watches low going, 1 high going
            sel_now = !(sync2[i] ^ ctrl[i].polarity);
            next_sel_prev[i] = sel_now;
            // a polarity flip moves sel_now and can fake an edge
            hit_edge = sel_now && !sel_prev[i];
            // level mode valid level is the inverse of sel_now
            valid_lvl = !sel_now;
            wr_ctrl = wr_take
                && addr_is(avs_address, epir_pkg::IDX_CTRL_BASE + 8'(i));
            next_ctrl[i] = ctrl[i];
            next_eff_lvl[i] = eff_lvl[i];
            next_lvl_cnt[i] = lvl_cnt[i];
            if (wr_ctrl) begin
                // software write sets or cancels the request bit
                next_ctrl[i] = avs_writedata[epir_pkg::CTRL_W-1:0];
                next_lvl_cnt[i] = det_cycles(det_sel);
            end else if (irq_accept[i] && !ctrl[i].sense) begin
                next_ctrl[i].request = 1'b0;
            end
            // a detected edge wins over any clear
            if (!ctrl[i].sense && hit_edge) begin
                next_ctrl[i].request = 1'b1;
            end
            // bit is set while sense is level and the pin is valid; invalid level never clears it
            if (ctrl[i].sense && valid_lvl) begin
                next_ctrl[i].request = 1'b1;
            end
            if (!wr_ctrl && lvl_cnt[i] != epir_pkg::CNT_ZERO) begin
                next_lvl_cnt[i] = lvl_cnt[i] - epir_pkg::CNT_ONE;
                // level lands on the counted edge
                if (lvl_cnt[i] == epir_pkg::CNT_ONE) begin
                    next_eff_lvl[i] = ctrl[i].level;
                end
            end
            // level mode looks at the pin, not the stored bit
            // present while the pin stays valid
            // nothing is kept once it goes invalid
            next_req[i] = (eff_lvl[i] != epir_pkg::LVL_OFF)
                && (ctrl[i].sense ? valid_lvl : ctrl[i].request);
            next_lvl_out[i*epir_pkg::LVL_W +: epir_pkg::LVL_W] = eff_lvl[i];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            // Pins idle high; a low reset value would fake a falling edge
            sync1 <= '1;
            sync2 <= '1;
            sel_prev <= '0;
            req_q <= '0;
            lvl_out_q <= '0;
            for (int i = 0; i < NUM_PINS; i++) begin
                ctrl[i] <= epir_pkg::CTRL_RESET;
                eff_lvl[i] <= epir_pkg::LVL_OFF;
                lvl_cnt[i] <= epir_pkg::CNT_ZERO;
            end
        end else begin
            // two-stage synchroniser, first stage read only here
            sync1 <= ext_irq_pin;
            sync2 <= sync1;
            sel_prev <= next_sel_prev;
            req_q <= next_req;
            lvl_out_q <= next_lvl_out;
            for (int i = 0; i < NUM_PINS; i++) begin
                ctrl[i] <= next_ctrl[i];
                eff_lvl[i] <= next_eff_lvl[i];
                lvl_cnt[i] <= next_lvl_cnt[i];
            end
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign irq_request = req_q;
    assign irq_level = lvl_out_q;
    assign port_two_pin_direction = p2_dir;
    assign port_five_pin_direction = p5_dir;
    assign port_seven_pin_direction = p7_dir;

endmodule

`default_nettype wire

// *** epir_pkg.sv ***
// Constants and types for the external pin interrupt request block
package epir_pkg;
    localparam int NUM_PINS = 5;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int LVL_W = 3;
    localparam int CNT_W = 3;

    // Register indexes; byte address is four times the index
    localparam logic [7:0] IDX_P2_DIR = 8'h08;
    localparam logic [7:0] IDX_P7_DIR = 8'h11;
    localparam logic [7:0] IDX_P5_DIR = 8'h12;
    localparam logic [7:0] IDX_CTRL_BASE = 8'h20;
    localparam logic [7:0] IDX_DET_TIME = 8'h28;
    localparam logic [7:0] IDX_STATUS = 8'h29;

    // Field positions
    localparam int CTRL_W = 6;
    localparam int DET_LO = 4;
    localparam int DET_W = 2;
    localparam int STAT_PIN_LO = 8;

    // Reset values and masks
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] P5_DIR_MASK = 8'he0;
    localparam logic [DET_W-1:0] DET_RESET = 2'h0;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

    // Detection time encodings and their cycle counts
    localparam logic [DET_W-1:0] DET_SEL_7 = 2'h0;
    localparam logic [DET_W-1:0] DET_SEL_4 = 2'h1;
    localparam logic [DET_W-1:0] DET_SEL_2 = 2'h2;
    localparam logic [CNT_W-1:0] DET_CYC_7 = 3'h7;
    localparam logic [CNT_W-1:0] DET_CYC_4 = 3'h4;
    localparam logic [CNT_W-1:0] DET_CYC_2 = 3'h2;
    localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
    localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
    localparam logic [LVL_W-1:0] LVL_OFF = 3'h0;

    // Per-pin control word, bit 5 down to bit 0
    typedef struct packed {
        logic sense;
        logic polarity;
        logic request;
        logic [LVL_W-1:0] level;
    } epir_ctrl_type;

    localparam epir_ctrl_type CTRL_RESET = 6'h00;
endpackage

// *** epir_top_monitor.sv ***
// Concurrent checks on the external pin interrupt block
`timescale 1ns/1ps
`default_nettype none
module epir_top_monitor #(
    parameter int NUM_PINS = epir_pkg::NUM_PINS
) (
    input wire logic clk, // Clock
    input wire logic reset_n, // Reset
    input wire logic [epir_pkg::ADDR_W-1:0] avs_address, // Address
    input wire logic avs_write, // Write
    input wire logic [epir_pkg::DATA_W-1:0] avs_writedata, // Data
    input wire logic avs_waitrequest, // Stall
    input wire logic [NUM_PINS-1:0] ext_irq_pin, // Pins
    input wire logic [NUM_PINS-1:0] irq_accept, // Accepts
    input wire logic [NUM_PINS-1:0] irq_request, // Requests
    input wire logic [NUM_PINS*epir_pkg::LVL_W-1:0] irq_level, // Levels
    input wire logic [7:0] port_two_pin_direction // Directions
);
    logic [5:0] ctl, next_ctl;
    logic [1:0] det, next_det;
    logic [3:0] calm, next_calm;
    logic wr, ctl_wr, edge_arm;
    assign wr = avs_write && !avs_waitrequest;
    assign ctl_wr = wr && avs_address == 10'h080;
    // Pin 0 only; long calm hides delayed level updates
    assign edge_arm = !ctl[5] && ctl[2:0] != 3'h0 && calm > 4'hb;
    always_comb begin
        next_ctl = ctl_wr ? avs_writedata[5:0] : ctl;
        next_det = (wr && avs_address == 10'h0a0) ? avs_writedata[5:4] : det;
        next_calm = (ctl_wr || irq_accept[0]) ? 4'h0 : calm + {3'h0, calm != 4'hf};
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl <= 6'h00;
            det <= 2'h0;
            calm <= 4'h0;
        end else begin
            ctl <= next_ctl;
            det <= next_det;
            calm <= next_calm;
        end
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    sequence held(v);
        (ctl[5] && ctl[2:0] != 3'h0 && calm > 4'hb && (ext_irq_pin[0] ^ ctl[4]) == v) [*6];
    endsequence
    chk_wait_one: assert property (avs_write && avs_waitrequest |=> !avs_waitrequest)
        else $error("write not answered after one wait state");
    chk_dir_reset: assert property ($rose(reset_n) |-> port_two_pin_direction == 8'h00)
        else $error("direction not input after reset");
    chk_lvl_zero: assert property (
        irq_level[2:0] == 3'h0 && $past(irq_level[2:0]) == 3'h0 |-> !irq_request[0])
        else $error("request with priority level zero");
    chk_edge_set: assert property (
        edge_arm && $changed(ext_irq_pin[0]) && ext_irq_pin[0] == ctl[4] |-> ##[1:6] irq_request[0])
        else $error("selected edge gave no request");
    chk_edge_hold: assert property (irq_request[0] && edge_arm |=> irq_request[0])
        else $error("edge request lost before acceptance");
    chk_lvl_valid: assert property (held(1'b1) |-> irq_request[0])
        else $error("valid level gave no request");
    chk_lvl_drop: assert property (held(1'b0) |-> !irq_request[0])
        else $error("request kept at invalid level");
    chk_pri_delay: assert property (
        ctl_wr && det == 2'h2 |=> $stable(irq_level[2:0]) [*2] ##[0:6] irq_level[2:0] == ctl[2:0])
        else $error("priority level change out of window");
endmodule
bind epir_top epir_top_monitor #(.NUM_PINS(NUM_PINS)) epir_top_monitor_i (.clk(clk),
    .reset_n(reset_n), .avs_address(avs_address), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
    .ext_irq_pin(ext_irq_pin), .irq_accept(irq_accept), .irq_request(irq_request),
    .irq_level(irq_level), .port_two_pin_direction(port_two_pin_direction));
`default_nettype wire

// *** epir_pin_model.sv ***
// Behavioural devices driving the interrupt pins
`timescale 1ns/1ps
`default_nettype none
module epir_pin_model (
    input wire logic clk, // Clock
    input wire logic [4:0] want, // Target levels
    input wire logic [3:0] lag, // Reaction delay
    output logic [4:0] pin // Pin levels
);
    logic [3:0] cnt = 4'h0;
    initial pin = 5'h1f;
    // Slow devices settle late but never glitch
    always @(posedge clk) begin
        cnt <= (want == pin || cnt >= lag) ? 4'h0 : cnt + 4'h1;
        if (want != pin && cnt >= lag) begin
            pin <= want;
        end
    end
endmodule
`default_nettype wire

// *** epir_top_tb.sv ***
// Self-checking bench for the external pin interrupt block
`timescale 1ns/1ps
`default_nettype none
module epir_top_tb;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic wait_req;
    logic [9:0] addr = 10'h000;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [4:0] pin;
    logic [4:0] want = 5'h1f;
    logic [4:0] accept = 5'h00;
    logic [4:0] req;
    logic [14:0] lvl;
    logic [7:0] dir2;
    logic [3:0] lag = 4'h0;
    int error_cnt = 0;
    int checks_done = 0;
    always #5 clk = ~clk;
    epir_pin_model epir_pin_model_i (.clk(clk), .want(want), .lag(lag), .pin(pin));
    epir_top epir_top_i (.clk(clk), .reset_n(reset_n), .avs_address(addr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata),
        .avs_waitrequest(wait_req), .ext_irq_pin(pin), .irq_accept(accept),
        .irq_request(req), .irq_level(lvl), .port_two_pin_direction(dir2),
        .port_five_pin_direction(), .port_seven_pin_direction());
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n = 0;
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        @(posedge clk);
        while (wait_req !== 1'b0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        q = rdata;
        error_cnt += (n == 20);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wr_reg(input logic [9:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input string what, input logic [9:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(what, q, exp);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic drive(input logic [4:0] v);
        int n = 0;
        @(posedge clk);
        want <= v;
        while (pin !== v && n < 40) begin
            @(posedge clk);
            n++;
        end
        settle(8);
    endtask
    task automatic t_regs;
        logic [9:0] at [6] = '{10'h020, 10'h044, 10'h048, 10'h080, 10'h0a0, 10'h3fc};
        for (int i = 0; i < 6; i++) begin
            rd_chk("reset value", at[i], 32'h0);
        end
        wr_reg(10'h020, 32'hff);
        wr_reg(10'h048, 32'hff);
        wr_reg(10'h3fc, 32'hff);
        rd_chk("port two", 10'h020, 32'hff);
        rd_chk("port five", 10'h048, 32'he0);
        rd_chk("unmapped", 10'h3fc, 32'h0);
        check("pin dir out", dir2, 8'hff);
        wr_reg(10'h044, 32'hff);
        rd_chk("port seven", 10'h044, 32'hff);
        // interrupt pins go back to input
        wr_reg(10'h020, 32'h0);
        wr_reg(10'h048, 32'h0);
        // converter and port seven pins go back to input too
        wr_reg(10'h044, 32'h0);
        $display("register test done");
    endtask
    task automatic t_prio;
        logic [1:0] sel [3] = '{2'h0, 2'h1, 2'h2};
        int cyc [3] = '{7, 4, 2};
        int k;
        for (int i = 0; i < 3; i++) begin
            wr_reg(10'h0a0, {26'h0, sel[i], 4'h0});
            wr_reg(10'h080, 32'(5 + i));
            k = 0;
            while (lvl[2:0] !== 3'(5 + i) && k < 20) begin
                settle(1);
                k++;
            end
            check("detect delay", k, cyc[i] + 1);
            // next level write spaced past detection time
            settle(8);
        end
        $display("priority test done");
    endtask
    task automatic t_edge;
        lag = 4'h5;
        wr_reg(10'h080, 32'h03);
        settle(12);
        drive(5'h1e);
        check("falling edge", req, 5'h01);
        drive(5'h1f);
        check("held", req, 5'h01);
        rd_chk("status", 10'h0a4, 32'h1f01);
        @(posedge clk);
        accept <= 5'h01;
        @(posedge clk);
        accept <= 5'h00;
        settle(4);
        check("accepted", req, 5'h00);
        wr_reg(10'h080, 32'h0b);
        settle(4);
        check("soft set", req, 5'h01);
        wr_reg(10'h080, 32'h03);
        settle(4);
        check("soft clear", req, 5'h00);
        wr_reg(10'h080, 32'h13);
        settle(8);
        wr_reg(10'h080, 32'h13);
        settle(12);
        check("flip cleared", req, 5'h00);
        drive(5'h1e);
        check("fall ignored", req, 5'h00);
        drive(5'h1f);
        check("rising edge", req, 5'h01);
        wr_reg(10'h080, 32'h10);
        settle(12);
        drive(5'h1e);
        drive(5'h1f);
        check("level zero", req, 5'h00);
        lag = 4'h0;
        $display("edge test done");
    endtask
    task automatic t_level;
        wr_reg(10'h080, 32'h33);
        settle(12);
        check("low idle", req, 5'h00);
        drive(5'h1e);
        settle(10);
        check("low level", req, 5'h01);
        drive(5'h1f);
        check("level gone", req, 5'h00);
        wr_reg(10'h080, 32'h23);
        settle(8);
        check("high level", req, 5'h01);
        wr_reg(10'h080, 32'h03);
        settle(8);
        wr_reg(10'h080, 32'h03);
        settle(4);
        check("switch cleared", req, 5'h00);
        $display("level test done");
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        t_regs;
        t_prio;
        t_edge;
        t_level;
        conclude;
    end
    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        conclude;
    end
endmodule
`default_nettype wire
